// ==== include/swfl_defs.svh ====
// constants for the status word flag logic: offsets, field positions, resets
`ifndef SWFL_DEFS_SVH
`define SWFL_DEFS_SVH
// byte addresses of the registers on the bus
`define SWFL_OFF_PSW 12'h000
`define SWFL_OFF_ACC 12'h004
`define SWFL_OFF_BREG 12'h008
`define SWFL_OFF_OP 12'h00C
`define SWFL_OFF_RES 12'h010
`define SWFL_OFF_BANK 12'h014
// field positions in the status word
`define SWFL_BIT_CY 7
`define SWFL_BIT_AC 6
`define SWFL_BIT_UA 5
`define SWFL_BIT_BSH 4
`define SWFL_BIT_BSL 3
`define SWFL_BIT_OV 2
`define SWFL_BIT_UB 1
`define SWFL_BIT_P 0
// reset values
`define SWFL_RST_PSW 8'h00
`define SWFL_RST_ACC 8'h00
`define SWFL_RST_BREG 8'h00
// operation codes written to the operation register
`define SWFL_OP_ADD 3'h1
`define SWFL_OP_ADDC 3'h2
`define SWFL_OP_SUBB 3'h3
`define SWFL_OP_MUL 3'h4
`define SWFL_OP_DIV 3'h5
// bank base spacing in RAM
`define SWFL_BANK_SPAN 8'h08
`endif

// ==== include/swfl_pkg.sv ====
// types shared by the status word flag logic
package swfl_pkg;
	typedef enum logic [2:0] {
		SWFL_NONE, SWFL_ADD, SWFL_ADDC, SWFL_SUBB, SWFL_MUL, SWFL_DIV
	} swfl_op_type;
	// arithmetic result with its flag updates
	typedef struct packed {
		logic [7:0] acc;
		logic [7:0] breg;
		logic cy;
		logic ac;
		logic ov;
		logic updAc;
	} swfl_result_type;
	// ahb-lite slave inputs that belong together
	typedef struct packed {
		logic hsel;
		logic [31:0] haddr;
		logic [1:0] htrans;
		logic hwrite;
		logic [2:0] hsize;
		logic hready;
	} swfl_ahb_req_type;
endpackage

// ==== hdl/swfl_alu.sv ====
// combinational arithmetic unit producing results and flag values
`timescale 1ns/1ps
`include "swfl_defs.svh"
module swfl_alu (
	input wire swfl_pkg::swfl_op_type op,
	input wire logic [7:0] accIn,
	input wire logic [7:0] bIn,
	input wire logic cyIn,
	output swfl_pkg::swfl_result_type res
);
	import swfl_pkg::*;
	logic [8:0] low7;
	logic [8:0] full;
	logic [4:0] nib;
	logic [15:0] prod;
	logic [7:0] subIn;
	logic cin;

	// add and subtract share one adder; subtract uses inverted operand
	always_comb begin
		subIn = (op == SWFL_SUBB) ? ~bIn : bIn;
		cin = (op == SWFL_ADD) ? 1'b0 : (op == SWFL_SUBB) ? ~cyIn : cyIn;
		low7 = {2'b00, accIn[6:0]} + {2'b00, subIn[6:0]} + {8'h00, cin};
		full = {1'b0, accIn} + {1'b0, subIn} + {8'h00, cin};
		nib = {1'b0, accIn[3:0]} + {1'b0, subIn[3:0]} + {4'h0, cin};
		prod = accIn * bIn;
		res = '0;
		res.acc = accIn;
		res.breg = bIn;
		unique case (op)
			SWFL_ADD, SWFL_ADDC, SWFL_SUBB: begin
				res.acc = full[7:0];
				// borrow is the inverse of the carry when subtracting
				res.cy = (op == SWFL_SUBB) ? ~full[8] : full[8];
				res.ac = (op == SWFL_SUBB) ? ~nib[4] : nib[4];
				res.updAc = 1'b1;
				// carry into bit 7 versus out of bit 7; same for borrows
				res.ov = low7[7] ^ full[8];
			end
			SWFL_MUL: begin
				res.acc = prod[7:0];
				res.breg = prod[15:8];
				res.cy = 1'b0;
				res.ov = (prod[15:8] != 8'h00);
			end
			SWFL_DIV: begin
				res.cy = 1'b0;
				// zero divisor: results left as-is, they are undefined anyway
				if (bIn == 8'h00) begin
					res.ov = 1'b1;
				end else begin
					res.acc = accIn / bIn;
					res.breg = accIn % bIn;
					res.ov = 1'b0;
				end
			end
			default: begin
				res.cy = cyIn;
			end
		endcase
	end
endmodule

// ==== hdl/swfl_status_word.sv ====
// status word flag logic with an ahb-lite register port
//
// Functional notes
// - two user flags at bits 5 and 1, freely written, no hardware effect.
// - bank bits map R0..R7 to 00-07H, 08-0FH, 10-17H or 18-1FH.
// - add sets overflow when exactly one of carry out bit 6/bit 7.
// - subtract sets overflow when borrow into exactly one of bit 6/bit 7.
// - multiply sets overflow when product exceeds 255, else clears it.
// - divide clears overflow; zero divisor sets it, results undefined.
// - parity flag is odd parity of accumulator, always current.
// - carry set on msb carry or borrow; zero after multiply or divide.
// - nibble carry set on carry out of or borrow into bit 3.
`timescale 1ns/1ps
`include "swfl_defs.svh"
module swfl_status_word (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire swfl_pkg::swfl_ahb_req_type ahbReq,
	input wire logic [31:0] hwdata,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	output logic [7:0] statusWord,
	output logic [7:0] bankBase
);
	import swfl_pkg::*;

	// ------------------------------------------------------------
	// functions
	// ------------------------------------------------------------
	// odd parity over the accumulator
	function automatic logic oddParity(input logic [7:0] v);
		oddParity = ^v;
	endfunction

	// first RAM address of the selected working bank
	function automatic logic [7:0] bankStart(input logic [1:0] sel);
		bankStart = 8'(sel) * `SWFL_BANK_SPAN;
	endfunction

	// translate the software op code into the op type
	function automatic swfl_op_type decodeOp(input logic [2:0] code);
		unique case (code)
			`SWFL_OP_ADD: decodeOp = SWFL_ADD;
			`SWFL_OP_ADDC: decodeOp = SWFL_ADDC;
			`SWFL_OP_SUBB: decodeOp = SWFL_SUBB;
			`SWFL_OP_MUL: decodeOp = SWFL_MUL;
			`SWFL_OP_DIV: decodeOp = SWFL_DIV;
			default: decodeOp = SWFL_NONE;
		endcase
	endfunction

	// a write data phase aimed at one register offset; shared by
	// the psw, acc, b and op registers so all four decode the same address compare
	function automatic logic hitWrite(input logic ph, input logic wr, input logic [11:0] addr,
		input logic [11:0] off);
		hitWrite = ph & wr & (addr == off);
	endfunction

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	logic [7:0] accReg;
	logic [7:0] bReg;
	logic carryOutFlag;
	logic nibbleCarryFlag;
	logic userFlagA;
	logic bankSelectHigh;
	logic bankSelectLow;
	logic signedWrapFlag;
	logic userFlagB;
	logic [2:0] lastOp;
	logic dataPhase;
	logic dataWrite;
	logic [11:0] dataAddr;
	logic opStrobe;
	swfl_op_type curOp;
	swfl_result_type aluRes;
	logic [7:0] program_status_word;
	logic [7:0] next_rdata;
	logic addrValid;
	// per-register write strobes of the data phase
	logic pswWrite;
	logic accWrite;
	logic bregWrite;
	logic opTaken;

	// assembled status word with live parity
	always_comb begin
		program_status_word = 8'h00;
		program_status_word[`SWFL_BIT_CY] = carryOutFlag;
		program_status_word[`SWFL_BIT_AC] = nibbleCarryFlag;
		program_status_word[`SWFL_BIT_UA] = userFlagA;
		program_status_word[`SWFL_BIT_BSH] = bankSelectHigh;
		program_status_word[`SWFL_BIT_BSL] = bankSelectLow;
		program_status_word[`SWFL_BIT_OV] = signedWrapFlag;
		program_status_word[`SWFL_BIT_UB] = userFlagB;
		program_status_word[`SWFL_BIT_P] = oddParity(accReg);
	end

	// ------------------------------------------------------------
	// bus slave
	// ------------------------------------------------------------
	// address phase taken on any nonseq/seq with hready high
	assign addrValid = ahbReq.hsel & ahbReq.hready & ahbReq.htrans[1];

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			dataPhase <= 1'b0;
			dataWrite <= 1'b0;
			dataAddr <= 12'h000;
		end else begin
			dataPhase <= addrValid;
			dataWrite <= addrValid & ahbReq.hwrite;
			if (addrValid) begin
				dataAddr <= ahbReq.haddr[11:0];
			end
		end
	end

	// zero wait states: every register answers in its data phase
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			hreadyout <= 1'b1;
		end else begin
			hreadyout <= 1'b1;
		end
	end

	// always okay; unmapped offsets read zero rather than raise an error,
	// since the core-side decode never issues a bad address
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			hresp <= 1'b0;
		end else begin
			hresp <= 1'b0;
		end
	end

	// write strobes decoded once; a write to the op register starts one operation
	assign opStrobe = hitWrite(dataPhase, dataWrite, dataAddr, `SWFL_OFF_OP);
	assign pswWrite = hitWrite(dataPhase, dataWrite, dataAddr, `SWFL_OFF_PSW);
	assign accWrite = hitWrite(dataPhase, dataWrite, dataAddr, `SWFL_OFF_ACC);
	assign bregWrite = hitWrite(dataPhase, dataWrite, dataAddr, `SWFL_OFF_BREG);
	// unknown op codes still strobe, but move no flag
	assign curOp = opStrobe ? decodeOp(hwdata[2:0]) : SWFL_NONE;
	assign opTaken = opStrobe & (curOp != SWFL_NONE);

	swfl_alu u_alu (
		.op(curOp),
		.accIn(accReg),
		.bIn(bReg),
		.cyIn(carryOutFlag),
		.res(aluRes)
	);

	// ------------------------------------------------------------
	// operands and results
	// ------------------------------------------------------------
	// accumulator: an op result wins over a direct write
	// one data phase carries one address, so op and load never meet
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			accReg <= `SWFL_RST_ACC;
		end else if (opStrobe) begin
			accReg <= aluRes.acc;
		end else if (accWrite) begin
			accReg <= hwdata[7:0];
		end
	end

	// b register takes the product high byte or the remainder
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			bReg <= `SWFL_RST_BREG;
		end else if (opStrobe) begin
			bReg <= aluRes.breg;
		end else if (bregWrite) begin
			bReg <= hwdata[7:0];
		end
	end

	// last op code kept for read-back; unknown codes are kept too,
	// so software can see what it actually wrote
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			lastOp <= 3'h0;
		end else if (opStrobe) begin
			lastOp <= hwdata[2:0];
		end
	end

	// ------------------------------------------------------------
	// arithmetic flags
	// ------------------------------------------------------------
	// the core never writes the status word while an op is in flight,
	// so op and direct write cannot meet; the op is given priority anyway
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			carryOutFlag <= 1'(`SWFL_RST_PSW >> `SWFL_BIT_CY);
		end else if (opTaken) begin
			carryOutFlag <= aluRes.cy;
		end else if (pswWrite) begin
			carryOutFlag <= hwdata[`SWFL_BIT_CY];
		end
	end

	// nibble carry: multiply and divide leave it as it was
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			nibbleCarryFlag <= 1'(`SWFL_RST_PSW >> `SWFL_BIT_AC);
		end else if (opTaken) begin
			if (aluRes.updAc) begin
				nibbleCarryFlag <= aluRes.ac;
			end
		end else if (pswWrite) begin
			nibbleCarryFlag <= hwdata[`SWFL_BIT_AC];
		end
	end

	// overflow: every known op rewrites it, set or clear
	// the alu folds add and subtract into one carry pair, so one path serves all
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			signedWrapFlag <= 1'(`SWFL_RST_PSW >> `SWFL_BIT_OV);
		end else if (opTaken) begin
			signedWrapFlag <= aluRes.ov;
		end else if (pswWrite) begin
			signedWrapFlag <= hwdata[`SWFL_BIT_OV];
		end
	end

	// ------------------------------------------------------------
	// software-owned bits
	// ------------------------------------------------------------
	// user flags: stored only; no hardware reads them
	// so software may use them as it likes
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			userFlagA <= 1'(`SWFL_RST_PSW >> `SWFL_BIT_UA);
			userFlagB <= 1'(`SWFL_RST_PSW >> `SWFL_BIT_UB);
		end else if (pswWrite) begin
			userFlagA <= hwdata[`SWFL_BIT_UA];
			userFlagB <= hwdata[`SWFL_BIT_UB];
		end
	end

	// bank select feeds the bank base seen by the core
	// a change takes effect for the core one edge later, through bankBase
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			bankSelectHigh <= 1'(`SWFL_RST_PSW >> `SWFL_BIT_BSH);
			bankSelectLow <= 1'(`SWFL_RST_PSW >> `SWFL_BIT_BSL);
		end else if (pswWrite) begin
			bankSelectHigh <= hwdata[`SWFL_BIT_BSH];
			bankSelectLow <= hwdata[`SWFL_BIT_BSL];
		end
	end

	// ------------------------------------------------------------
	// read data and outputs
	// ------------------------------------------------------------
	// read mux looks ahead so hrdata is registered for the data phase
	always_comb begin
		next_rdata = 8'h00;
		unique case (ahbReq.haddr[11:0])
			`SWFL_OFF_PSW: next_rdata = program_status_word;
			`SWFL_OFF_ACC: next_rdata = accReg;
			`SWFL_OFF_BREG: next_rdata = bReg;
			`SWFL_OFF_OP: next_rdata = {5'h00, lastOp};
			`SWFL_OFF_BANK: next_rdata = bankStart({bankSelectHigh, bankSelectLow});
			default: next_rdata = 8'h00;
		endcase
	end

	// a read right after a write to the same word sees old data; limitation
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			hrdata <= 32'h0000_0000;
		end else if (addrValid & ~ahbReq.hwrite) begin
			hrdata <= {24'h000000, next_rdata};
		end
	end

	// status word copy for the core; it trails the flags by one edge,
	// as does hrdata, which a bus read registers from the same live word
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			statusWord <= `SWFL_RST_PSW;
		end else begin
			statusWord <= program_status_word;
		end
	end

	// bank base for the core's working register decode
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			bankBase <= 8'h00;
		end else begin
			bankBase <= bankStart({bankSelectHigh, bankSelectLow});
		end
	end
endmodule

// ==== tb/swfl_status_word_asserts.sv ====
// port checker for the status word flag logic
`timescale 1ns/1ps
`include "swfl_defs.svh"
module swfl_status_word_asserts
	import swfl_pkg::*;
(
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire swfl_pkg::swfl_ahb_req_type ahbReq,
	input wire logic [31:0] hwdata,
	input wire logic [31:0] hrdata,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic [7:0] statusWord,
	input wire logic [7:0] bankBase
);
	logic take;
	logic wrPsw;
	logic wrOp;
	logic rdAny;
	logic rdVoid;
	assign take = ahbReq.hsel & ahbReq.hready & ahbReq.htrans[1];
	// data phase flags, one per kind of transfer
	always_ff @(posedge clk_sys) begin
		wrPsw <= !sys_rst & take & ahbReq.hwrite & (ahbReq.haddr[11:0] == `SWFL_OFF_PSW);
		wrOp <= !sys_rst & take & ahbReq.hwrite & (ahbReq.haddr[11:0] == `SWFL_OFF_OP);
		rdAny <= !sys_rst & take & !ahbReq.hwrite;
		rdVoid <= !sys_rst & take & !ahbReq.hwrite & (ahbReq.haddr[11:0] == `SWFL_OFF_RES
			|| ahbReq.haddr[11:0] > `SWFL_OFF_BANK);
	end
	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (sys_rst);
	ready_high_a: assert property (hreadyout) else $error("slave not ready");
	resp_okay_a: assert property (!hresp) else $error("response not okay");
	// two settled cycles asked for, though the address register and the word update on the same edge
	bank_map_a: assert property ($stable(statusWord[4:3]) [*2] |->
		bankBase == {3'h0, statusWord[4:3], 3'h0}) else $error("bank base wrong");
	// flags change at the end of the data phase, the port copy one edge later
	user_flags_a: assert property (wrPsw |-> ##2 (statusWord[5:3] == $past(hwdata[5:3], 2)
		&& statusWord[1] == $past(hwdata[1], 2))) else $error("user bits not written");
	flags_hold_a: assert property (!wrPsw |-> ##2 ($stable(statusWord[5:3])
		&& $stable(statusWord[1]))) else $error("user bits moved");
	mul_carry_a: assert property (wrOp && hwdata[2:0] inside {`SWFL_OP_MUL, `SWFL_OP_DIV}
		|-> ##2 !statusWord[7]) else $error("carry after multiply or divide");
	unmapped_zero_a: assert property (rdVoid |-> hrdata == 32'h0) else $error("void read");
	upper_zero_a: assert property (rdAny |-> hrdata[31:8] == 24'h0) else $error("upper bits");
	cover property (wrOp && hwdata[2:0] == `SWFL_OP_DIV);
	cover property (wrPsw && hwdata[4:3] == 2'h3);
	cover property (rdVoid);
endmodule
bind swfl_status_word swfl_status_word_asserts chk (.clk_sys(clk_sys), .sys_rst(sys_rst),
	.ahbReq(ahbReq), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
	.statusWord(statusWord), .bankBase(bankBase));

// ==== tb/status_word_flag_logic_tb.sv ====
// self-checking bench for the status word flag logic
`timescale 1ns/1ps
`include "swfl_defs.svh"
module status_word_flag_logic_tb;
	import swfl_pkg::*;
	logic clk_sys = 1'b0;
	logic sys_rst = 1'b1;
	swfl_ahb_req_type req = '0;
	swfl_ahb_req_type ahbIn;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata;
	logic hreadyout;
	logic hresp;
	logic [7:0] statusWord;
	logic [7:0] bankBase;
	logic rdPend = 1'b0;
	logic [31:0] expQ[$];
	logic [31:0] rng = 32'h00016E11;
	int nErrors = 0;
	int checksDone = 0;
	// the single slave's ready is the bus ready
	assign ahbIn = {req.hsel, req.haddr, req.htrans, req.hwrite, req.hsize, hreadyout};
	swfl_status_word dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .ahbReq(ahbIn), .hwdata(hwdata),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .statusWord(statusWord),
		.bankBase(bankBase));
	// 250 MHz clock
	initial forever #2 clk_sys = ~clk_sys;
	// ------------------------------------------------------------
	// tasks
	// ------------------------------------------------------------
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] t;
		t = s ^ (s << 13);
		t = t ^ (t >> 17);
		return t ^ (t << 5);
	endfunction
	// expected {acc, b, carry, nibble carry, overflow}
	function automatic logic [18:0] model(input logic [2:0] op, input logic [7:0] a, b,
		input logic c, h);
		logic [8:0] s;
		logic [15:0] p;
		p = a * b;
		c = c & (op != `SWFL_OP_ADD);
		if (op == `SWFL_OP_SUBB) begin
			s = {1'b0, a} - b - c;
			return {s[7:0], b, s[8], {1'b0, a[3:0]} < b[3:0] + c,
				({1'b0, a[6:0]} < b[6:0] + c) ^ s[8]};
		end
		s = a + b + c;
		if (op == `SWFL_OP_MUL) return {p[7:0], p[15:8], 1'b0, h, p[15:8] != 8'h00};
		if (op == `SWFL_OP_DIV && b == 8'h00) return {a, b, 1'b0, h, 1'b1};
		if (op == `SWFL_OP_DIV) return {a / b, a % b, 1'b0, h, 1'b0};
		return {s[7:0], b, s[8], (a[3:0] + b[3:0] + c) > 5'h0F,
			((a[6:0] + b[6:0] + c) > 8'h7F) ^ s[8]};
	endfunction
	task automatic miss(input string m);
		nErrors++;
		$display("MISMATCH t=%0t %s", $time, m);
	endtask
	task automatic closeOut();
		$display("checks %0d mismatches %0d", checksDone, nErrors);
		if (nErrors == 0 && checksDone > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	task automatic cmpWord(input logic [31:0] got, input logic [31:0] exp);
		checksDone++;
		if (got !== exp) miss($sformatf("read %h expected %h", got, exp));
	endtask
	// no open wait: a stuck ready ends the run
	task automatic waitReady();
		int n = 0;
		@(posedge clk_sys);
		while (hreadyout !== 1'b1) begin
			if (++n > 50) begin
				miss("ready timeout");
				closeOut();
			end
			@(posedge clk_sys);
		end
	endtask
	task automatic bus(input logic [11:0] a, input logic w, input logic [7:0] d);
		req.hsel <= 1'b1;
		req.haddr <= {20'h0, a};
		req.htrans <= 2'h2;
		req.hwrite <= w;
		req.hsize <= 3'h2;
		waitReady();
		req.hsel <= 1'b0;
		req.htrans <= 2'h0;
		hwdata <= {24'h0, d};
		rdPend <= !w;
		waitReady();
		rdPend <= 1'b0;
	endtask
	task automatic rd(input logic [11:0] a, input logic [7:0] e);
		expQ.push_back({24'h0, e});
		bus(a, 1'b0, 8'h00);
	endtask
	// oldest note against the data phase answer
	always @(posedge clk_sys) begin
		if (rdPend && hreadyout) begin
			if (expQ.size() == 0) miss("unexpected read");
			else cmpWord(hrdata, expQ.pop_front());
		end
	end
	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		logic [18:0] e;
		logic [2:0] op;
		logic [7:0] a;
		logic [7:0] b;
		logic [7:0] ps;
		repeat (5) @(posedge clk_sys);
		sys_rst <= 1'b0;
		rd(`SWFL_OFF_PSW, 8'h00);
		// every bank code with random user bits
		for (int i = 0; i < 4; i++) begin
			rng = xs(rng);
			ps = {2'h0, rng[0], i[1:0], 1'b0, rng[1], 1'b0};
			bus(`SWFL_OFF_PSW, 1'b1, ps);
			rd(`SWFL_OFF_PSW, ps);
			rd(`SWFL_OFF_BANK, {3'h0, i[1:0], 3'h0});
		end
		$display("flags and banks done");
		// every operation, a zero divisor at the first divide
		for (int i = 0; i < 20; i++) begin
			rng = xs(rng);
			op = 3'(i % 5 + 1);
			a = rng[7:0];
			b = (i == 4) ? 8'h00 : rng[15:8];
			ps = {rng[16], rng[17], 6'h00};
			e = model(op, a, b, ps[7], ps[6]);
			bus(`SWFL_OFF_ACC, 1'b1, a);
			bus(`SWFL_OFF_BREG, 1'b1, b);
			bus(`SWFL_OFF_PSW, 1'b1, ps);
			bus(`SWFL_OFF_OP, 1'b1, {5'h0, op});
			rd(`SWFL_OFF_PSW, {e[2:1], 3'h0, e[0], 1'b0, ^e[18:11]});
			rd(`SWFL_OFF_ACC, e[18:11]);
			rd(`SWFL_OFF_BREG, e[10:3]);
		end
		$display("arithmetic done");
		bus(12'h020, 1'b1, 8'hFF);
		rd(12'h020, 8'h00);
		rd(`SWFL_OFF_RES, 8'h00);
		$display("unmapped done");
		closeOut();
	end
endmodule
